// >>> rtl/srrc_top.sv
// stand-by RAM retention controller: freeze, supply switch, strobe isolation
//
// Behaviour
// - clearing the enable freezes the retained RAM interface at once
// - any reset event switches RAM supply to the stand-by reference
// - RAM stays frozen until software sets the enable again
// - low core supply keeps RAM frozen only while the enable bit is clear
// - with enable set, a core supply dip causes no stand-by switching
// - isolation stage blocks decaying write strobes during power-off
// - stand-by exit follows normal power-on with RAM already back on the main supply
// - low-voltage detector holds reset until core supply exceeds about 1 V
// - reset event release switches frozen RAM supply back to main, before internal reset lifts
// - real-time clock counts in stand-by only on the 32 kHz reference
module srrc_top
  import srrc_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic EXTERNAL_RESET_INPUT_N,
  input wire logic CORE_SUPPLY_ABOVE_1V,
  input wire logic CORE_BELOW_STANDBY_REF,
  input wire logic ENABLE_WRITE,
  input wire logic ENABLE_WDATA,
  input wire logic RTC_USES_LP_OSC,
  input wire logic RTC_TICK_MAIN,
  input wire logic RTC_TICK_LP,
  input wire logic RAM_CE_IN,
  input wire logic RAM_WE_IN,
  input wire logic RAM_OE_IN,
  output logic RETAINED_RAM_INTERFACE_ENABLE,
  output logic RAM_FREEZE,
  output logic RAM_SUPPLY_STANDBY,
  output logic INTERNAL_RESET,
  output logic RAM_CE_OUT,
  output logic RAM_WE_OUT,
  output logic RAM_OE_OUT,
  output logic RTC_TICK
);
  srrc_state_e state;
  srrc_state_e next_state;
  logic enable;
  logic next_enable;
  logic switch_active;
  logic next_freeze;
  logic reset_event;
  logic [7:0] wake_count;
  logic [7:0] next_wake_count;
  logic next_supply_standby;
  logic next_rtc_tick;
  logic [2:0] iso_in;
  logic [2:0] iso_out;

  // the core may be in reset from either source; the detector wins at low supply
  assign reset_event = ~EXTERNAL_RESET_INPUT_N | ~CORE_SUPPLY_ABOVE_1V;

  // sequencer: run, stand-by on reset, wake once reset lifts
  always_comb begin
    next_state = state;
    case (state)
      SRRC_ST_RESET: begin
        if (!reset_event) begin
          next_state = SRRC_ST_WAKE;
        end
      end
      SRRC_ST_RUN: begin
        if (reset_event) begin
          next_state = SRRC_ST_STANDBY;
        end
      end
      SRRC_ST_STANDBY: begin
        if (!reset_event) begin
          next_state = SRRC_ST_WAKE;
        end
      end
      SRRC_ST_WAKE: begin
        if (reset_event) begin
          next_state = SRRC_ST_STANDBY;
        end else if (wake_count == 8'h00) begin
          next_state = SRRC_ST_RUN;
        end
      end
      default: begin
        next_state = SRRC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= SRRC_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // reset hold after any reset event
  // any new reset event restarts the hold, so a glitchy release cannot shorten it
  always_comb begin
    next_wake_count = wake_count;
    if (reset_event) begin
      next_wake_count = SRRC_WAKE_CYCLES;
    end else if (state == SRRC_ST_WAKE && wake_count != 8'h00) begin
      next_wake_count = wake_count - 8'h01;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wake_count <= SRRC_WAKE_CYCLES;
    end else begin
      wake_count <= next_wake_count;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      INTERNAL_RESET <= 1'b1;
    end else begin
      INTERNAL_RESET <= reset_event || (next_state != SRRC_ST_RUN);
    end
  end

  // enable bit: cleared by any reset, written only while running
  // frozen until set
  // a write loses to a reset event: software cannot thaw a RAM that is powering down
  always_comb begin
    next_enable = enable;
    if (reset_event || state != SRRC_ST_RUN) begin
      next_enable = 1'b0;
    end else if (ENABLE_WRITE) begin
      next_enable = ENABLE_WDATA;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      enable <= SRRC_ENABLE_RESET;
    end else begin
      enable <= next_enable;
    end
  end
  assign RETAINED_RAM_INTERFACE_ENABLE = enable;

  // switching circuit: a supply dip only counts while the enable is clear
  // low supply forces freeze
  // dip ignored when enabled
  // uses the next enable so freeze and enable never disagree for a cycle
  assign switch_active = (state != SRRC_ST_RUN) || reset_event ||
                         (CORE_BELOW_STANDBY_REF && !next_enable);

  assign next_freeze = switch_active || !next_enable;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RAM_FREEZE <= SRRC_FREEZE_RESET;
    end else begin
      RAM_FREEZE <= next_freeze;
    end
  end

  // switch back on reset release
  // the RAM is still frozen here, so the supply change cannot meet a live strobe
  always_comb begin
    next_supply_standby = RAM_SUPPLY_STANDBY;
    if (reset_event) begin
      next_supply_standby = 1'b1;
    end else if (state == SRRC_ST_STANDBY || state == SRRC_ST_RESET) begin
      next_supply_standby = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RAM_SUPPLY_STANDBY <= SRRC_SRC_STBY_RESET;
    end else begin
      RAM_SUPPLY_STANDBY <= next_supply_standby;
    end
  end

  // strobe isolation stage
  // freeze is computed combinationally so the gate tracks the same edge as the flop
  srrc_isolate #(
    .WIDTH(3)
  ) u_iso (
    .clk(CLK),
    .rst(SYS_RST),
    .freeze(next_freeze),
    .strobe_in(iso_in),
    .strobe_out(iso_out)
  );
  assign iso_in = {RAM_CE_IN, RAM_WE_IN, RAM_OE_IN};
  assign RAM_CE_OUT = iso_out[2];
  assign RAM_WE_OUT = iso_out[1];
  assign RAM_OE_OUT = iso_out[0];

  // rtc reference choice
  // main oscillator ticks are lost once main power goes, so they only count while running
  always_comb begin
    if (RTC_USES_LP_OSC) begin
      next_rtc_tick = RTC_TICK_LP;
    end else begin
      next_rtc_tick = RTC_TICK_MAIN && !reset_event && state == SRRC_ST_RUN;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RTC_TICK <= 1'b0;
    end else begin
      RTC_TICK <= next_rtc_tick;
    end
  end
endmodule // srrc_top

// >>> shared/srrc_pkg.sv
// package for the stand-by RAM retention controller
package srrc_pkg;
  // supply source selection for the retained RAM
  typedef enum logic [1:0] {
    SRRC_SRC_MAIN,
    SRRC_SRC_STANDBY
  } srrc_src_e;
  // sequencer states
  typedef enum logic [2:0] {
    SRRC_ST_RESET,
    SRRC_ST_RUN,
    SRRC_ST_STANDBY,
    SRRC_ST_WAKE
  } srrc_state_e;
  localparam logic SRRC_ENABLE_RESET = 1'b0;
  localparam logic SRRC_FREEZE_RESET = 1'b1;
  localparam logic SRRC_SRC_STBY_RESET = 1'b1;
  // power-on hold after the last reset event releases, in ns, and its cycle count
  localparam int SRRC_CLK_PERIOD_NS = 4;
  localparam int SRRC_WAKE_HOLD_NS = 64;
  localparam logic [7:0] SRRC_WAKE_CYCLES =
    8'((SRRC_WAKE_HOLD_NS + SRRC_CLK_PERIOD_NS - 1) / SRRC_CLK_PERIOD_NS);
endpackage

// >>> rtl/srrc_isolate.sv
// isolation stage for RAM strobes, on the switched RAM supply
module srrc_isolate
  import srrc_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic freeze,
  input wire logic [WIDTH-1:0] strobe_in,
  output logic [WIDTH-1:0] strobe_out
);
  // gate every strobe bit with the freeze so a sagging core strobe reads inactive
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          strobe_out[i] <= 1'b0;
        end else begin
          strobe_out[i] <= strobe_in[i] & ~freeze;
        end
      end
    end
  endgenerate
endmodule // srrc_isolate

// >>> dv/srrc_supply_model.sv
// supply supervisor and external reset model
module srrc_supply_model (
  input wire logic clk,
  input wire logic pwr,
  output logic rst_n = 1'b0,
  output logic above = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int ramp = 0;
  // reset held low until supply settles
  always @(posedge clk) begin
    ramp <= pwr ? ramp + 1 : 0;
    above <= pwr && ramp > 8;
    rst_n <= pwr && ramp > 24;
  end
endmodule // srrc_supply_model

// >>> dv/srrc_assertions.sv
// port checks for the retention controller
module srrc_assertions (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic EXTERNAL_RESET_INPUT_N,
  input wire logic CORE_SUPPLY_ABOVE_1V,
  input wire logic ENABLE_WRITE,
  input wire logic ENABLE_WDATA,
  input wire logic RAM_WE_IN,
  input wire logic RETAINED_RAM_INTERFACE_ENABLE,
  input wire logic RAM_FREEZE,
  input wire logic RAM_SUPPLY_STANDBY,
  input wire logic INTERNAL_RESET,
  input wire logic RAM_WE_OUT
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  wire ev = !EXTERNAL_RESET_INPUT_N || !CORE_SUPPLY_ABOVE_1V;
  to_standby_a: assert property (ev |=> RAM_SUPPLY_STANDBY && INTERNAL_RESET)
    else $error("no standby");
  back_main_a: assert property ($fell(ev) |=> ev || !RAM_SUPPLY_STANDBY)
    else $error("no switch back");
  wake_hold_a: assert property ($fell(ev) |=> INTERNAL_RESET ##17 !INTERNAL_RESET)
    else $error("bad wake hold");
  one_freeze_a: assert property (RAM_FREEZE != RETAINED_RAM_INTERFACE_ENABLE)
    else $error("freeze mismatch");
  clear_freeze_a: assert property (ENABLE_WRITE && !ENABLE_WDATA |=> RAM_FREEZE)
    else $error("no freeze");
  set_thaw_a: assert property (ENABLE_WRITE && ENABLE_WDATA && !INTERNAL_RESET && !ev
    |=> ev || !RAM_FREEZE) else $error("no thaw");
  we_block_a: assert property (RAM_FREEZE |-> !RAM_WE_OUT)
    else $error("strobe leak");
  we_pass_a: assert property (!RAM_FREEZE && !ev && !ENABLE_WRITE
    |=> ev || RAM_WE_OUT == $past(RAM_WE_IN)) else $error("strobe lost");
endmodule // srrc_assertions
bind srrc_top srrc_assertions srrc_assertions_inst (.*);

// >>> dv/tb_top.sv
// self-checking bench for the retention controller
module tb_top
  import srrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RUN = SRRC_WAKE_CYCLES + 2;
  logic clk = 0, rst = 1, pwr = 0, br = 0, wr = 0, wd = 0, lp = 0, tm = 0, tl = 0;
  logic ce = 0, we = 0, oe = 0, rn, a1, en, fz, sb, ir, co, wo, oo, rt;
  bit m_en, m_ce, m_we, m_oe, m_rt;
  int errors = 0, total_checks = 0, cnt = 0;
  always #2 clk = ~clk;
  srrc_supply_model srrc_supply_model_inst (.clk(clk), .pwr(pwr), .rst_n(rn), .above(a1));
  srrc_top srrc_top_inst (.CLK(clk), .SYS_RST(rst), .EXTERNAL_RESET_INPUT_N(rn),
    .CORE_SUPPLY_ABOVE_1V(a1), .CORE_BELOW_STANDBY_REF(br), .ENABLE_WRITE(wr),
    .ENABLE_WDATA(wd), .RTC_USES_LP_OSC(lp), .RTC_TICK_MAIN(tm), .RTC_TICK_LP(tl),
    .RAM_CE_IN(ce), .RAM_WE_IN(we), .RAM_OE_IN(oe), .RETAINED_RAM_INTERFACE_ENABLE(en),
    .RAM_FREEZE(fz), .RAM_SUPPLY_STANDBY(sb), .INTERNAL_RESET(ir), .RAM_CE_OUT(co),
    .RAM_WE_OUT(wo), .RAM_OE_OUT(oo), .RTC_TICK(rt));
  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // reference model; skipped while a reset event may act between edges
  always @(posedge clk) begin
    if (rst || !rn || !a1) begin
      cnt = 0;
      {m_en, m_ce, m_we, m_oe} = 0;
    end else begin
      check("supply rst", {sb, ir}, {cnt < 1, cnt < RUN});
      check("en freeze", {en, fz}, {m_en, !m_en});
      check("strobes", {co, wo, oo}, {m_ce, m_we, m_oe});
      if (cnt > RUN) check("rtc", rt, m_rt);
      if (wr && cnt >= RUN) m_en = wd;
      {m_ce, m_we, m_oe} = {ce, we, oe} & {3{m_en}};
      m_rt = lp ? tl : tm;
      if (cnt <= RUN) cnt++;
    end
  end
  initial begin
    void'($urandom(81));
    repeat (12) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 6; i++) begin
      // supply ramps first; early writes must be ignored
      pwr <= 1;
      repeat (300) begin
        {wr, wd, br, lp, tm, tl, ce, we, oe} <= 9'($urandom);
        @(posedge clk);
      end
      // clear the enable, then drop supply with strobes still live
      wr <= 1;
      wd <= 0;
      @(posedge clk);
      pwr <= 0;
      br <= 1;
      repeat (20) @(posedge clk);
    end
    complete_run();
  end
  // about 1950 cycles expected
  initial begin
    #9600;
    errors++;
    complete_run();
  end
endmodule // tb_top
